// [rtl/smc_standby_ctrl.sv]
/*
  Standby mode controller: light sleep, deep sleep, interrupt wake-up
  and the oscillator stabilization wait after deep-sleep release.
  Assumes all inputs synchronous to sys_clk_i; oscillator ticks are
  one-cycle pulses, one per oscillator period; sleep requests are
  one-cycle pulses from the CPU core.
*/
`timescale 1ns/100ps

`include "smc_defines.svh"

module smc_standby_ctrl
  import smc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic      sys_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      ce_i,
  // CPU requests
  input  wire logic      light_sleep_req_i,
  input  wire logic      deep_sleep_req_i,
  input  wire logic      irq_i,
  input  wire smc_src_e  clk_src_i,
  // Clock control bits
  input  wire logic      main_osc_halt_bit_i,
  input  wire logic      main_clock_cut_bit_i,
  input  wire logic      internal_osc_halt_bit_i,
  input  wire logic      int_osc_stoppable_i,
  // Oscillator ticks
  input  wire logic      main_osc_tick_i,
  input  wire logic      int_osc_tick_i,
  // Wait select write
  input  wire logic      wait_sel_we_i,
  input  wire smc_wsel_t wait_sel_data_i,
  // Clock and hold outputs
  output logic           cpu_clk_en_o,
  output logic           main_osc_en_o,
  output logic           int_osc_en_o,
  output logic           hold_o,
  output smc_src_e       cpu_clk_src_o,
  // Status
  output smc_state_e     state_o,
  output smc_wsel_t      stabilization_wait_select_o,
  output smc_prog_t      stabilization_progress_status_o
);

  smc_state_e               state_reg;
  smc_state_e               state_next;
  smc_src_e                 src_reg;
  smc_wsel_t                wsel_reg;
  logic                     run_reg;
  logic                     cpu_en_reg;
  logic                     main_en_reg;
  logic                     int_en_reg;
  logic                     hold_reg;
  logic [`SMC_INT_CNT_W-1:0] int_cnt_reg;
  logic                     int_wait_end;
  logic                     deep_ok;

  smc_stab_if st ();

  smc_stab_counter u_cnt (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .st        (st.cnt)
  );

  // deep request from subsystem clock is ignored
  assign deep_ok = deep_sleep_req_i && clk_src_i != SMC_SRC_SUB;
  assign int_wait_end = int_osc_tick_i &&
                        int_cnt_reg == `SMC_INT_WAIT - `SMC_INT_CNT_W'(1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SMC_ST_RUN: begin
        if (deep_ok) begin
          state_next = SMC_ST_DEEP;
        end else if (light_sleep_req_i) begin
          state_next = SMC_ST_LIGHT;
        end
      end
      SMC_ST_LIGHT: begin
        if (irq_i) begin
          state_next = SMC_ST_RUN;
        end
      end
      SMC_ST_DEEP: begin
        // interrupt release, wait chosen by source
        if (irq_i) begin
          state_next = (src_reg == SMC_SRC_INT) ? SMC_ST_WAIT_INT :
                                                  SMC_ST_WAIT_MAIN;
        end
      end
      SMC_ST_WAIT_MAIN: begin
        if (st.done) begin
          state_next = SMC_ST_RUN;
        end
      end
      SMC_ST_WAIT_INT: begin
        if (int_wait_end) begin
          state_next = SMC_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= SMC_ST_RUN;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // source frozen from entry until resume
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      src_reg <= SMC_SRC_INT;
    end else if (ce_i && state_reg == SMC_ST_RUN) begin
      src_reg <= clk_src_i;
    end
  end

  // wait select loads its reset code
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wsel_reg <= `SMC_WSEL_RST;
    end else if (ce_i && wait_sel_we_i) begin
      wsel_reg <= wait_sel_data_i;
    end
  end

  // counting restarts after reset and after deep release
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      run_reg <= 1'b1;
    end else if (ce_i) begin
      if (state_reg == SMC_ST_DEEP && irq_i) begin
        run_reg <= 1'b1;
      end else if (st.clr) begin
        run_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      int_cnt_reg <= '0;
    end else if (ce_i) begin
      if (state_reg != SMC_ST_WAIT_INT) begin
        int_cnt_reg <= '0;
      end else if (int_osc_tick_i) begin
        int_cnt_reg <= int_cnt_reg + `SMC_INT_CNT_W'(1);
      end
    end
  end

  // Outputs follow the next state so they line up with state_reg.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cpu_en_reg  <= 1'b1;
      main_en_reg <= 1'b0;
      int_en_reg  <= 1'b1;
      hold_reg    <= 1'b0;
    end else if (ce_i) begin
      cpu_en_reg  <= state_next == SMC_ST_RUN;
      // crystal off in deep sleep; untouched in light sleep
      main_en_reg <= state_next != SMC_ST_DEEP && !main_osc_halt_bit_i;
      // halt bit gated by option; deep sleep ignored
      int_en_reg  <= !(internal_osc_halt_bit_i && int_osc_stoppable_i);
      hold_reg    <= state_next != SMC_ST_RUN;
    end
  end

  // Clearing on deep entry also discards a stale progress record.
  assign st.clr  = (state_reg == SMC_ST_RUN && deep_ok) ||
                   main_osc_halt_bit_i || main_clock_cut_bit_i;
  assign st.run  = run_reg;
  assign st.tick = main_osc_tick_i;
  assign st.sel  = wsel_reg;

  assign cpu_clk_en_o                    = cpu_en_reg;
  assign main_osc_en_o                   = main_en_reg;
  assign int_osc_en_o                    = int_en_reg;
  assign hold_o                          = hold_reg;
  assign cpu_clk_src_o                   = src_reg;
  assign state_o                         = state_reg;
  assign stabilization_wait_select_o     = wsel_reg;
  assign stabilization_progress_status_o = st.prog;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  light_gate_a: assert property (state_reg == SMC_ST_LIGHT |->
    !cpu_clk_en_o && hold_o)
    else $error("CPU clock running in light sleep");
  light_osc_a: assert property (ce_i && state_reg == SMC_ST_LIGHT &&
    !main_osc_halt_bit_i |=> main_osc_en_o)
    else $error("Crystal stopped in light sleep");
  deep_stop_a: assert property (state_reg == SMC_ST_DEEP |->
    !main_osc_en_o && !cpu_clk_en_o)
    else $error("Crystal running in deep sleep");
  deep_wake_a: assert property (ce_i && state_reg == SMC_ST_DEEP &&
    irq_i |=> state_reg inside {SMC_ST_WAIT_MAIN, SMC_ST_WAIT_INT})
    else $error("Deep sleep not released by interrupt");
  deep_wait_a: assert property (ce_i && state_reg == SMC_ST_DEEP &&
    irq_i |=> !cpu_clk_en_o)
    else $error("CPU resumed without stabilization wait");
  light_wake_a: assert property (ce_i && state_reg == SMC_ST_LIGHT &&
    irq_i |=> cpu_clk_en_o && !hold_o)
    else $error("Light sleep resume not immediate");
  hold_sleep_a: assert property (state_reg != SMC_ST_RUN |->
    hold_o)
    else $error("State not held in sleep");
  sub_refuse_a: assert property (ce_i && state_reg == SMC_ST_RUN &&
    deep_sleep_req_i && clk_src_i == SMC_SRC_SUB |=>
    state_reg != SMC_ST_DEEP)
    else $error("Deep sleep entered from subsystem clock");
  light_any_a: assert property (ce_i && state_reg == SMC_ST_RUN &&
    light_sleep_req_i && !deep_sleep_req_i |=> state_reg == SMC_ST_LIGHT)
    else $error("Light sleep request refused");
  int_keep_a: assert property (ce_i && state_reg == SMC_ST_DEEP &&
    !internal_osc_halt_bit_i |=> int_osc_en_o)
    else $error("Internal oscillator stopped in deep sleep");
  int_wait_a: assert property (state_reg == SMC_ST_WAIT_INT &&
    cpu_clk_en_o == 1'b0 ##1 cpu_clk_en_o |->
    $past(int_cnt_reg) == `SMC_INT_WAIT - `SMC_INT_CNT_W'(1))
    else $error("Internal restart wait not 17 periods");
  src_keep_a: assert property ($rose(cpu_clk_en_o) |->
    cpu_clk_src_o == $past(cpu_clk_src_o))
    else $error("Clock source changed across sleep");
  opt_gate_a: assert property (ce_i && !int_osc_stoppable_i |=>
    int_osc_en_o)
    else $error("Internal oscillator stopped without option");
  wsel_rst_a: assert property (rst_n_i && $past(!rst_n_i) |->
    stabilization_wait_select_o == `SMC_WSEL_RST)
    else $error("Wait select reset value wrong");
  main_wait_a: assert property (state_reg == SMC_ST_WAIT_MAIN &&
    !st.done |=> !cpu_clk_en_o)
    else $error("CPU resumed before crystal wait");

  light_trip_c: cover property (state_reg == SMC_ST_LIGHT ##1
    state_reg == SMC_ST_RUN);
  main_trip_c: cover property (state_reg == SMC_ST_WAIT_MAIN ##1
    state_reg == SMC_ST_RUN);
  int_trip_c: cover property (state_reg == SMC_ST_WAIT_INT ##1
    state_reg == SMC_ST_RUN);
  sub_deny_c: cover property (state_reg == SMC_ST_RUN &&
    deep_sleep_req_i && clk_src_i == SMC_SRC_SUB);

endmodule

// [rtl/smc_defines.svh]
/*
  Constants of the standby mode controller: stabilization wait codes,
  counter stage layout and the internal-oscillator restart wait.
  Assumes it is included by its bare name, before the package.
*/
// Functional notes
// - Light-sleep instruction gates the CPU clock off.
// - Light sleep leaves every running oscillator running.
// - Deep-sleep instruction stops main crystal, halts clocks.
// - Interrupt request releases deep sleep.
// - Deep-sleep release holds CPU for stabilization wait.
// - Light-sleep release on interrupt is immediate.
// - Registers, flags and memory held in sleep.
// - Port latches and buffers held in sleep.
// - Light sleep accepted from any clock source.
// - Internal oscillator keeps running through deep sleep.
// - Internal clock: CPU stopped 17 periods after release.
// - Deep-sleep release resumes on the entry source.
// - Light-sleep release resumes on the entry source.
// - Internal halt bit honoured only if stoppable option.
// - Wait select loads 05H at reset, codes 2^11, 2^13..2^16.
// - Progress bits set highest stage first, stay set.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

`define SMC_WSEL_W     3
`define SMC_WSEL_RST   3'h5
`define SMC_WSEL_MIN   3'h1
`define SMC_WSEL_MAX   3'h5
`define SMC_STAGES     5
`define SMC_EXP_FIRST  5'h0b
`define SMC_EXP_TOP    5'h10
`define SMC_INT_CNT_W  5
`define SMC_INT_WAIT   5'h11

`endif

// [rtl/smc_pkg.sv]
/*
  Types shared by the standby mode controller modules.
  Assumes smc_defines.svh is on the include path.
*/
`include "smc_defines.svh"

package smc_pkg;

  typedef enum logic [1:0] {
    SMC_SRC_MAIN,
    SMC_SRC_INT,
    SMC_SRC_SUB
  } smc_src_e;

  typedef enum logic [2:0] {
    SMC_ST_RUN,
    SMC_ST_LIGHT,
    SMC_ST_DEEP,
    SMC_ST_WAIT_MAIN,
    SMC_ST_WAIT_INT
  } smc_state_e;

  typedef logic [`SMC_WSEL_W-1:0] smc_wsel_t;
  typedef logic [`SMC_STAGES-1:0] smc_prog_t;

endpackage

// [rtl/smc_stab_if.sv]
/*
  Link between the standby controller and its stabilization counter.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps

interface smc_stab_if;
  import smc_pkg::*;

  logic      clr;
  logic      run;
  logic      tick;
  smc_wsel_t sel;
  smc_prog_t prog;
  logic      done;

  modport ctrl (output clr, output run, output tick, output sel,
                input prog, input done);
  modport cnt  (input clr, input run, input tick, input sel,
                output prog, output done);
endinterface

// [rtl/smc_stab_counter.sv]
/*
  Main-oscillator stabilization counter with staged progress flags.
  Assumes tick pulses once per main crystal period, synchronous to clk.
*/
`timescale 1ns/100ps

`include "smc_defines.svh"

module smc_stab_counter
  import smc_pkg::*;
#(
  parameter int CNT_W = int'(`SMC_EXP_TOP) + 1
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Controller side
  smc_stab_if.cnt   st
);

  logic [CNT_W-1:0] cnt_reg;
  smc_prog_t        prog_reg;
  smc_prog_t        prog_set;
  logic [2:0]       sel_idx;

  // Illegal select codes fall back to the longest wait.
  assign sel_idx = (st.sel >= `SMC_WSEL_MIN && st.sel <= `SMC_WSEL_MAX) ?
                   3'(`SMC_WSEL_MAX - st.sel) : 3'h0;
  assign st.done = prog_reg[sel_idx];
  assign st.prog = prog_reg;

  for (genvar i = 0; i < `SMC_STAGES; i++) begin : g_stage
    localparam int EXP = (i == `SMC_STAGES - 1) ? int'(`SMC_EXP_FIRST) :
                         int'(`SMC_EXP_TOP) - i;
    localparam logic [CNT_W-1:0] THR = CNT_W'(1) << EXP;
    assign prog_set[i] = st.run && st.tick && !st.done &&
                         (cnt_reg + CNT_W'(1) == THR);
  end

  // Counting stops once the selected wait is reached.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (st.clr) begin
        cnt_reg <= '0;
      end else if (st.run && st.tick && !st.done) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prog_reg <= '0;
    end else if (ce_i) begin
      prog_reg <= (prog_reg & ~{`SMC_STAGES{st.clr}}) | prog_set;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  prog_sticky_a: assert property (ce_i && !st.clr |=>
    (prog_reg & $past(prog_reg)) == $past(prog_reg))
    else $error("Progress flag dropped without clear");
  for (genvar j = 0; j < `SMC_STAGES - 1; j++) begin : g_ord
    prog_order_a: assert property (prog_reg[j] |->
      prog_reg[j+1])
      else $error("Progress flag set out of order");
  end

endmodule

// [verification/smc_cpu_model.sv]
/*
  CPU core model: issues sleep instructions and the wake-up interrupt.
  Assumes the controller samples its requests on the rising edge.
*/
`timescale 1ns/100ps

module smc_cpu_model
  import smc_pkg::*;
(
  // Clock
  input  wire logic sys_clk_i,
  // Requests to the controller
  output logic      light_sleep_req_o,
  output logic      deep_sleep_req_o,
  output logic      irq_o,
  output smc_src_e  clk_src_o
);
  logic periph_run;
  logic conv_run;

  initial begin
    light_sleep_req_o = 1'b0;
    deep_sleep_req_o  = 1'b0;
    irq_o             = 1'b0;
    clk_src_o         = SMC_SRC_INT;
    periph_run        = 1'b1;
    conv_run          = 1'b1;
  end

  task automatic set_src(input smc_src_e src);
    @(negedge sys_clk_i);
    clk_src_o = src;
  endtask

  // A rude request skips the source check so the refusal can be seen.
  task automatic sleep(input logic deep, input logic rude);
    @(negedge sys_clk_i);
    conv_run = 1'b0;
    periph_run = !deep;
    deep_sleep_req_o  = deep && !periph_run &&
                        (rude || clk_src_o != SMC_SRC_SUB);
    light_sleep_req_o = !deep && !conv_run;
    @(negedge sys_clk_i);
    light_sleep_req_o = 1'b0;
    deep_sleep_req_o  = 1'b0;
  endtask

  task automatic wake();
    @(negedge sys_clk_i);
    irq_o = 1'b1;
    @(negedge sys_clk_i);
    irq_o      = 1'b0;
    periph_run = 1'b1;
    conv_run   = 1'b1;
  endtask
endmodule

// [verification/smc_standby_ctrl_test.sv]
/*
  Self-checking bench: controller against an integer state model.
  Assumes the design samples every input on the rising clock edge.
*/
`timescale 1ns/100ps

module smc_standby_ctrl_test;
  import smc_pkg::*;

  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        light_req, deep_req, irq;
  smc_src_e    clk_src, cpu_src;
  logic        int_halt = 1'b0;
  logic        ce = 1'b1;
  logic        main_halt = 1'b0;
  logic        main_cut = 1'b0;
  logic        int_stop_ok = 1'b0;
  logic        main_tick = 1'b0;
  logic        int_tick = 1'b0;
  logic        wsel_we = 1'b0;
  smc_wsel_t   wsel_data = 3'h0;
  logic        clk_en, main_en, int_en, hold;
  smc_state_e  state;
  smc_wsel_t   wsel;
  smc_prog_t   prog;
  logic [31:0] num_errors = 0;
  logic [31:0] comparisons = 0;
  logic [31:0] icnt = 0;
  logic [31:0] mcnt = 0;
  logic [31:0] cyc = 0;
  int          seed = 81;
  int          m_st = 0;
  int          exp_tab [8] = '{16, 11, 13, 14, 15, 16, 16, 16};
  smc_src_e    src_q [$];

  smc_cpu_model smc_cpu_model_inst (.sys_clk_i(sys_clk_i),
    .light_sleep_req_o(light_req), .deep_sleep_req_o(deep_req),
    .irq_o(irq), .clk_src_o(clk_src));

  smc_standby_ctrl smc_standby_ctrl_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce), .light_sleep_req_i(light_req),
    .deep_sleep_req_i(deep_req), .irq_i(irq), .clk_src_i(clk_src),
    .main_osc_halt_bit_i(main_halt), .main_clock_cut_bit_i(main_cut),
    .internal_osc_halt_bit_i(int_halt),
    .int_osc_stoppable_i(int_stop_ok), .main_osc_tick_i(main_tick),
    .int_osc_tick_i(int_tick), .wait_sel_we_i(wsel_we),
    .wait_sel_data_i(wsel_data), .cpu_clk_en_o(clk_en),
    .main_osc_en_o(main_en), .int_osc_en_o(int_en), .hold_o(hold),
    .cpu_clk_src_o(cpu_src), .state_o(state),
    .stabilization_wait_select_o(wsel),
    .stabilization_progress_status_o(prog));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Oscillators tick only while enabled; the internal one runs slower.
  always @(negedge sys_clk_i) begin
    cyc       <= cyc + 1;
    main_tick <= main_en;
    int_tick  <= int_en && (cyc % 3 == 0);
  end

  always @(posedge sys_clk_i) begin
    if (state === SMC_ST_WAIT_INT && int_tick === 1'b1) icnt <= icnt + 1;
    if (state === SMC_ST_WAIT_MAIN && main_tick === 1'b1) mcnt <= mcnt + 1;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic check_state();
    check("state", 32'(state), 32'(m_st));
    check("cpu_clk_en", 32'(clk_en), 32'(m_st == 0));
    check("hold", 32'(hold), 32'(m_st != 0));
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic wait_run(input int limit);
    int n;
    n = 0;
    m_st = 0;
    while (state !== SMC_ST_RUN && n < limit) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (state !== SMC_ST_RUN) begin
      num_errors++;
      $display("mismatch wait_run expected 0 seen %0d", state);
      final_report();
    end
  endtask

  task automatic sel_write(input smc_wsel_t code);
    @(negedge sys_clk_i);
    wsel_we   = 1'b1;
    wsel_data = code;
    @(negedge sys_clk_i);
    wsel_we = 1'b0;
    check("wait_sel", 32'(wsel), 32'(code));
  endtask

  task automatic deep_main(input smc_wsel_t code, input smc_prog_t pexp);
    sel_write(code);
    smc_cpu_model_inst.set_src(SMC_SRC_MAIN);
    smc_cpu_model_inst.sleep(1'b1, 1'b0);
    m_st = 2;
    check_state();
    check("main_osc_en", 32'(main_en), 32'h0);
    mcnt = 0;
    smc_cpu_model_inst.wake();
    m_st = 3;
    check_state();
    wait_run(70000);
    check_state();
    check("main_ticks", mcnt, (32'h1 << exp_tab[code]) + 1);
    check("progress", 32'(prog), 32'(pexp));
    check("src", 32'(cpu_src), 32'(SMC_SRC_MAIN));
    $display("test deep_main code %0d done", code);
  endtask

  initial begin
    int k;
    cycles(12);
    rst_n_i = 1'b1;
    cycles(1);
    check_state();
    check("wait_sel", 32'(wsel), 32'h5);
    check("progress", 32'(prog), 32'h0);
    check("src", 32'(cpu_src), 32'(SMC_SRC_INT));
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      src_q.push_back(smc_src_e'(k));
      smc_cpu_model_inst.set_src(smc_src_e'(k));
      smc_cpu_model_inst.sleep(1'b0, 1'b0);
      m_st = 1;
      cycles(1 + ($unsigned($random(seed)) % 8));
      check_state();
      check("osc_on", 32'({main_en, int_en}), 32'h3);
      smc_cpu_model_inst.wake();
      m_st = 0;
      check_state();
      check("src", 32'(cpu_src), 32'(src_q.pop_front()));
    end
    $display("test light done");
    smc_cpu_model_inst.set_src(SMC_SRC_SUB);
    smc_cpu_model_inst.sleep(1'b1, 1'b1);
    check_state();
    $display("test refused done");
    smc_cpu_model_inst.set_src(SMC_SRC_INT);
    smc_cpu_model_inst.sleep(1'b1, 1'b0);
    m_st = 2;
    check_state();
    check("int_osc_en", 32'(int_en), 32'h1);
    icnt = 0;
    smc_cpu_model_inst.wake();
    m_st = 4;
    check_state();
    wait_run(300);
    check("int_ticks", icnt, 32'd17);
    check("src", 32'(cpu_src), 32'(SMC_SRC_INT));
    $display("test deep_int done");
    deep_main(3'h1, 5'b1_0000);
    deep_main(3'h2, 5'b1_1000);
    int_halt = 1'b1;
    cycles(3);
    check("int_osc_en", 32'(int_en), 32'h1);
    int_stop_ok = 1'b1;
    cycles(3);
    check("int_osc_en", 32'(int_en), 32'h0);
    int_halt = 1'b0;
    cycles(3);
    check("int_osc_en", 32'(int_en), 32'h1);
    $display("test halt_bit done");
    main_cut = 1'b1;
    cycles(2);
    check("progress", 32'(prog), 32'h0);
    check("main_osc_en", 32'(main_en), 32'h1);
    main_cut  = 1'b0;
    main_halt = 1'b1;
    cycles(2);
    check("main_osc_en", 32'(main_en), 32'h0);
    main_halt = 1'b0;
    cycles(2);
    check("main_osc_en", 32'(main_en), 32'h1);
    $display("test main_bits done");
    smc_cpu_model_inst.sleep(1'b0, 1'b0);
    m_st = 1;
    ce   = 1'b0;
    smc_cpu_model_inst.wake();
    check_state();
    ce = 1'b1;
    smc_cpu_model_inst.wake();
    m_st = 0;
    check_state();
    $display("test freeze done");
    smc_cpu_model_inst.sleep(1'b1, 1'b0);
    rst_n_i = 1'b0;
    cycles(2);
    m_st = 0;
    check_state();
    check("wait_sel", 32'(wsel), 32'h5);
    check("src", 32'(cpu_src), 32'(SMC_SRC_INT));
    rst_n_i = 1'b1;
    cycles(1);
    check_state();
    check("main_osc_en", 32'(main_en), 32'h1);
    $display("test reset_in_sleep done");
    final_report();
  end
endmodule
